// [rtl/agl_pkg.sv]
/*
  package for the input gain and output level control block:
  register offsets, field positions, reset values, timing counts,
  carrier structs and the level-control state enum.
  assumes one fs tick per word clock, delivered with each sample pair.
*/
package agl_pkg;

  // ==========================================================
  // register offsets
  localparam logic [4:0] ADDR_CH_SEL = 5'h01;
  localparam logic [4:0] ADDR_MUTE = 5'h02;
  localparam logic [4:0] ADDR_GAIN_L = 5'h04;
  localparam logic [4:0] ADDR_GAIN_R = 5'h05;
  localparam logic [4:0] ADDR_ATT_L = 5'h08;
  localparam logic [4:0] ADDR_ATT_R = 5'h09;
  localparam logic [4:0] ADDR_ALC_CTRL = 5'h0A;
  localparam logic [4:0] ADDR_ALC_TIME = 5'h0B;
  localparam logic [4:0] ADDR_ALC_REF = 5'h0C;
  localparam logic [4:0] ADDR_STATUS = 5'h0D;

  // ==========================================================
  // field positions
  localparam int MUTE_BIT = 0;
  localparam int ALC_EN_BIT = 0;
  localparam int ZC_DIS_BIT = 1;
  localparam int FAST_BIT = 2;
  localparam int LIM_LVL_BIT = 3;
  localparam int LIM_STEP_LSB = 4;
  localparam int ZC_TMO_LSB = 0;
  localparam int LIM_TMO_LSB = 2;
  localparam int WAIT_TMO_LSB = 4;
  localparam int REC_STEP_BIT = 6;

  // ==========================================================
  // reset values
  localparam logic [2:0] CH_SEL_RST = 3'h0;
  localparam logic [7:0] GAIN_RST = 8'h80;
  localparam logic [7:0] ATT_RST = 8'h7F;
  localparam logic [7:0] ALC_CTRL_RST = 8'h00;
  localparam logic [7:0] ALC_TIME_RST = 8'h02;
  localparam logic [7:0] ALC_REF_RST = 8'h90;

  // ==========================================================
  // gain code limits
  localparam logic [7:0] GAIN_MAX = 8'hA4;
  localparam logic [7:0] GAIN_ALC_AREA = 8'h7F;
  localparam logic [7:0] ATT_MUTE = 8'h00;

  // ==========================================================
  // timing counts in fs periods
  localparam logic [13:0] ZC_TMO0 = 14'd288;
  localparam logic [13:0] ZC_TMO1 = 14'd1152;
  localparam logic [13:0] ZC_TMO2 = 14'd2304;
  localparam logic [13:0] ZC_TMO3 = 14'd4608;
  localparam logic [13:0] LIM_TMO0 = 14'd36;
  localparam logic [13:0] LIM_TMO1 = 14'd72;
  localparam logic [13:0] LIM_TMO2 = 14'd144;
  localparam logic [13:0] LIM_TMO3 = 14'd288;
  localparam logic [13:0] WAIT_TMO0 = 14'd288;
  localparam logic [13:0] WAIT_TMO1 = 14'd1152;
  localparam logic [13:0] WAIT_TMO2 = 14'd2304;
  localparam logic [13:0] WAIT_TMO3 = 14'd4608;
  localparam int FAST_SHIFT = 2;
  localparam int MUTE_FS = 1028;
  localparam int ATT_STEPS = 143;
  localparam logic [3:0] RAMP_TICKS = 4'(MUTE_FS / ATT_STEPS);

  // ==========================================================
  // detector levels, magnitude of 24-bit samples
  localparam logic [23:0] LIM_LVL0 = 24'h5A0000;
  localparam logic [23:0] LIM_LVL1 = 24'h400000;
  localparam int REC_SHIFT = 1;
  localparam logic [23:0] IMPULSE_LVL = 24'h7C0000;

  // ==========================================================
  // carriers and states
  typedef logic [13:0] agl_cnt_t;

  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    logic [7:0] data;
  } agl_wr_s;

  typedef struct packed {
    logic valid;
    logic [23:0] left;
    logic [23:0] right;
  } agl_smp_s;

  typedef enum logic [2:0] {
    ALC_OFF = 3'b001,
    ALC_LIMIT = 3'b010,
    ALC_RECOVER = 3'b100
  } agl_alc_e;

endpackage

// [rtl/agl_gain_chan.sv]
/*
  one channel of the input gain stage: holds the applied gain and a
  pending code that lands at a zero crossing or on timeout.
  assumes fs_tick and zero_cross come from the clk_sys domain.
*/
`timescale 1ns/10ps
module agl_gain_chan import agl_pkg::*; #(
  parameter int GW = 8,
  parameter int CW = 14
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic fs_tick,
  input wire logic zero_cross,
  input wire logic load,
  input wire logic [GW-1:0] load_val,
  input wire logic force_en,
  input wire logic [GW-1:0] force_val,
  input wire logic [CW-1:0] tmo,
  output logic [GW-1:0] gain_q,
  output logic pending_q
);

  if (GW < 6 || CW < 13) begin : g_chk
    $error("agl_gain_chan: widths too small");
  end

  typedef struct packed {
    logic [GW-1:0] gain;
    logic pend;
    logic [GW-1:0] pend_val;
    logic [CW-1:0] cnt;
  } agl_chan_s;

  agl_chan_s q;
  agl_chan_s d;

  // ==========================================================
  // pending gain update
  always_comb begin
    d = q;
    if (force_en) begin
      d.gain = force_val;
      d.pend = 1'b0;
      d.cnt = '0;
    end else if (load) begin
      d.pend = 1'b1; // R7
      d.pend_val = load_val; // R7
      d.cnt = '0; // R7
    end else if (q.pend && fs_tick) begin
      if (zero_cross || (q.cnt + CW'(1)) >= tmo) begin
        d.gain = q.pend_val; // R5
        d.pend = 1'b0;
        d.cnt = '0;
      end else begin
        d.cnt = q.cnt + CW'(1); // R6
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q <= '{gain: GW'(GAIN_RST), pend: 1'b0, pend_val: GW'(GAIN_RST), cnt: '0};
    end else begin
      q <= d;
    end
  end

  assign gain_q = q.gain;
  assign pending_q = q.pend;

  // ==========================================================
  // checks
  a_load_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
    load && !force_en |=> q.pend && q.cnt == '0 && q.pend_val == $past(load_val)) // R7
    else $error("new gain did not restart the pending update");

  a_zc_apply: assert property (@(posedge clk_sys) disable iff (!nrst)
    q.pend && fs_tick && zero_cross && !load && !force_en |=> !q.pend && q.gain == $past(q.pend_val)) // R5
    else $error("pending gain not applied at zero crossing");

  a_tmo_bound: assert property (@(posedge clk_sys) disable iff (!nrst)
    q.pend && fs_tick && !zero_cross && !load && !force_en && (q.cnt + CW'(1)) >= tmo |=> !q.pend) // R6
    else $error("pending gain outlived its timeout");

  c_zc_apply: cover property (@(posedge clk_sys) disable iff (!nrst)
    q.pend && fs_tick && zero_cross ##1 !q.pend);

endmodule // agl_gain_chan

// [rtl/agl_top.sv]
/*
  input gain and output level control of a stereo audio converter:
  host register port, soft mute, output attenuator ramp, input gain
  stages and automatic level control with limiter and recovery.
  assumes samples arrive once per fs on clk_sys with a valid strobe,
  and the mute pin is asynchronous.
*/
// Operation
// [R1] host mutes before switching input channel
// [R2] host keeps channel switch mute about 200 ms
// [R3] full mute ramp from +8 dB within 1028 fs
// [R4] two independent 37-level input gain stages
// [R5] gain changes at zero crossing or timeout
// [R6] timeout select 288/1152/2304/4608 fs
// [R7] new write replaces pending gain, restarts timer
// [R8] gain writes above 7FH ignored under level control
// [R9] leaving level control restores host gain
// [R10] attenuation writes always take effect
// [R11] two 144-level attenuators ramp without steps
// [R12] host never writes attenuation above 90H
// [R13] attenuation code linear, 00H means mute
// [R14] limiter lowers both gains together
// [R15] zero-cross disabled uses limiter timeout
// [R16] zero-cross mode steps at crossings, timeout
// [R17] fast response shortens steps on impulses; code does not shorten limiter steps with zero-cross disabled
// [R18] recovery raises gain stepwise to reference
// [R19] overload during recovery returns to limiter
// [R20] recovery reset level restarts wait timer
// [R21] level control starts from left gain
// [R22] host keeps level settings still meanwhile
// [R23] mute is pin or bit, ramps 1028
// [R24] zero crossing is sign change of samples
`timescale 1ns/10ps
module agl_top import agl_pkg::*; (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire agl_wr_s reg_wr,
  input wire logic [4:0] reg_rd_addr,
  output logic [7:0] reg_rd_data_q,
  input wire logic mute_pin,
  input wire agl_smp_s smp,
  output logic [2:0] ch_sel_q,
  output logic [7:0] gain_l_q,
  output logic [7:0] gain_r_q,
  output logic [7:0] att_l_q,
  output logic [7:0] att_r_q
);

  typedef struct packed {
    logic [2:0] ch_sel;
    logic mute_bit;
    logic [7:0] host_gain_l;
    logic [7:0] host_gain_r;
    logic [7:0] att_reg_l;
    logic [7:0] att_reg_r;
    logic [7:0] alc_ctrl;
    logic [7:0] alc_time;
    logic [7:0] alc_ref;
    logic mute_s1;
    logic mute_s2;
    logic sign_l;
    logic sign_r;
    logic [7:0] att_cur_l;
    logic [7:0] att_cur_r;
    logic [3:0] ramp_cnt;
    agl_alc_e alc;
    agl_cnt_t alc_cnt;
    logic [7:0] alc_gain;
    logic [7:0] rd_data;
  } agl_top_s;

  agl_top_s q;
  agl_top_s d;

  logic alc_on;
  logic mute_req;
  logic zc_l;
  logic zc_r;
  logic [23:0] mag_l;
  logic [23:0] mag_r;
  logic [23:0] lim_lvl;
  logic over_lim;
  logic over_rec;
  logic impulse;
  agl_cnt_t zc_tmo;
  agl_cnt_t lim_tmo;
  agl_cnt_t wait_tmo;
  agl_cnt_t step_tmo;
  agl_cnt_t rec_tmo;
  logic [7:0] lim_step;
  logic [7:0] rec_step;
  logic [8:0] rec_sum;
  logic load_l;
  logic load_r;
  logic [7:0] load_val_l;
  logic [7:0] load_val_r;
  logic force_en;
  logic [7:0] force_val;
  logic pend_l;
  logic pend_r;

  function automatic logic [23:0] agl_mag(input logic [23:0] s);
    agl_mag = s[23] ? (24'h000000 - s) : s;
  endfunction

  function automatic agl_cnt_t agl_pick(input logic [1:0] sel, input agl_cnt_t t0, input agl_cnt_t t1,
                                        input agl_cnt_t t2, input agl_cnt_t t3);
    case (sel)
      2'b00: agl_pick = t0;
      2'b01: agl_pick = t1;
      2'b10: agl_pick = t2;
      default: agl_pick = t3;
    endcase
  endfunction

  // ==========================================================
  // detectors and settings
  always_comb begin
    alc_on = q.alc_ctrl[ALC_EN_BIT];
    mute_req = q.mute_bit | q.mute_s2; // R23
    zc_l = smp.valid && (smp.left[23] != q.sign_l); // R24
    zc_r = smp.valid && (smp.right[23] != q.sign_r); // R24
    mag_l = agl_mag(smp.left);
    mag_r = agl_mag(smp.right);
    lim_lvl = q.alc_ctrl[LIM_LVL_BIT] ? LIM_LVL1 : LIM_LVL0;
    over_lim = (mag_l > lim_lvl) || (mag_r > lim_lvl);
    over_rec = (mag_l >= (lim_lvl >> REC_SHIFT)) || (mag_r >= (lim_lvl >> REC_SHIFT));
    impulse = q.alc_ctrl[FAST_BIT] && ((mag_l >= IMPULSE_LVL) || (mag_r >= IMPULSE_LVL));
    zc_tmo = agl_pick(q.alc_time[ZC_TMO_LSB +: 2], ZC_TMO0, ZC_TMO1, ZC_TMO2, ZC_TMO3); // R6
    lim_tmo = agl_pick(q.alc_time[LIM_TMO_LSB +: 2], LIM_TMO0, LIM_TMO1, LIM_TMO2, LIM_TMO3);
    wait_tmo = agl_pick(q.alc_time[WAIT_TMO_LSB +: 2], WAIT_TMO0, WAIT_TMO1, WAIT_TMO2, WAIT_TMO3);
    if (q.alc_ctrl[ZC_DIS_BIT]) begin
      step_tmo = lim_tmo; // R15
    end else begin
      step_tmo = impulse ? (zc_tmo >> FAST_SHIFT) : zc_tmo; // R16 R17
    end
    rec_tmo = impulse ? (wait_tmo >> FAST_SHIFT) : wait_tmo; // R17
    lim_step = {6'h00, q.alc_ctrl[LIM_STEP_LSB +: 2]} + 8'h01;
    rec_step = q.alc_time[REC_STEP_BIT] ? 8'h02 : 8'h01;
    rec_sum = {1'b0, q.alc_gain} + {1'b0, rec_step};
  end

  // ==========================================================
  // registers, level control, attenuator ramp
  always_comb begin
    d = q;
    load_l = 1'b0;
    load_r = 1'b0;
    load_val_l = q.host_gain_l;
    load_val_r = q.host_gain_r;
    force_en = 1'b0;
    force_val = q.alc_gain;
    d.mute_s1 = mute_pin;
    d.mute_s2 = q.mute_s1;
    if (reg_wr.wr) begin
      case (reg_wr.addr)
        ADDR_CH_SEL: d.ch_sel = reg_wr.data[2:0];
        ADDR_MUTE: d.mute_bit = reg_wr.data[MUTE_BIT];
        ADDR_GAIN_L: begin
          if (!(alc_on && reg_wr.data > GAIN_ALC_AREA)) begin // R8
            d.host_gain_l = (reg_wr.data > GAIN_MAX) ? GAIN_MAX : reg_wr.data; // R4
            load_l = !alc_on;
            load_val_l = d.host_gain_l;
          end
        end
        ADDR_GAIN_R: begin
          if (!(alc_on && reg_wr.data > GAIN_ALC_AREA)) begin // R8
            d.host_gain_r = (reg_wr.data > GAIN_MAX) ? GAIN_MAX : reg_wr.data; // R4
            load_r = !alc_on;
            load_val_r = d.host_gain_r;
          end
        end
        ADDR_ATT_L: d.att_reg_l = reg_wr.data; // R10
        ADDR_ATT_R: d.att_reg_r = reg_wr.data; // R10
        ADDR_ALC_CTRL: d.alc_ctrl = reg_wr.data;
        ADDR_ALC_TIME: d.alc_time = reg_wr.data;
        ADDR_ALC_REF: d.alc_ref = reg_wr.data;
        default: d.ch_sel = q.ch_sel;
      endcase
    end
    if (smp.valid) begin
      d.sign_l = smp.left[23];
      d.sign_r = smp.right[23];
    end
    case (q.alc)
      ALC_OFF: begin
        if (alc_on) begin
          d.alc = ALC_RECOVER;
          d.alc_cnt = '0;
          d.alc_gain = gain_l_q; // R21
          force_en = 1'b1;
          force_val = gain_l_q; // R21
        end
      end
      ALC_LIMIT: begin
        if (!alc_on) begin
          d.alc = ALC_OFF;
          load_l = 1'b1; // R9
          load_r = 1'b1; // R9
        end else if (smp.valid) begin
          if (over_lim) begin
            if ((!q.alc_ctrl[ZC_DIS_BIT] && (zc_l || zc_r)) || (q.alc_cnt + 14'h0001) >= step_tmo) begin // R16 R15
              d.alc_gain = (q.alc_gain > lim_step) ? (q.alc_gain - lim_step) : 8'h00; // R14
              force_en = 1'b1; // R14
              force_val = d.alc_gain;
              d.alc_cnt = '0;
            end else begin
              d.alc_cnt = q.alc_cnt + 14'h0001;
            end
          end else begin
            d.alc = ALC_RECOVER; // R18
            d.alc_cnt = '0;
          end
        end
      end
      ALC_RECOVER: begin
        if (!alc_on) begin
          d.alc = ALC_OFF;
          load_l = 1'b1; // R9
          load_r = 1'b1; // R9
        end else if (smp.valid) begin
          if (over_lim) begin
            d.alc = ALC_LIMIT; // R19
            d.alc_cnt = '0;
          end else if (over_rec) begin
            d.alc_cnt = '0; // R20
          end else if ((q.alc_cnt + 14'h0001) >= rec_tmo) begin
            d.alc_cnt = '0;
            if (q.alc_gain < q.alc_ref) begin
              d.alc_gain = (rec_sum > {1'b0, q.alc_ref}) ? q.alc_ref : rec_sum[7:0]; // R18
              force_en = 1'b1; // R18
              force_val = d.alc_gain;
            end
          end else begin
            d.alc_cnt = q.alc_cnt + 14'h0001; // R18
          end
        end
      end
      default: begin
        d.alc = ALC_OFF;
        d.alc_cnt = '0;
      end
    endcase
    if (smp.valid) begin
      if ((q.ramp_cnt + 4'h1) >= RAMP_TICKS) begin
        d.ramp_cnt = 4'h0;
        // codes are linear half-dB steps, so one code per step
        if (q.att_cur_l < (mute_req ? ATT_MUTE : q.att_reg_l)) begin // R13 R23
          d.att_cur_l = q.att_cur_l + 8'h01; // R11
        end else if (q.att_cur_l > (mute_req ? ATT_MUTE : q.att_reg_l)) begin // R3
          d.att_cur_l = q.att_cur_l - 8'h01; // R11
        end
        if (q.att_cur_r < (mute_req ? ATT_MUTE : q.att_reg_r)) begin // R13 R23
          d.att_cur_r = q.att_cur_r + 8'h01; // R11
        end else if (q.att_cur_r > (mute_req ? ATT_MUTE : q.att_reg_r)) begin // R3
          d.att_cur_r = q.att_cur_r - 8'h01; // R11
        end
      end else begin
        d.ramp_cnt = q.ramp_cnt + 4'h1;
      end
    end
    case (reg_rd_addr)
      ADDR_CH_SEL: d.rd_data = {5'h00, q.ch_sel};
      ADDR_MUTE: d.rd_data = {7'h00, q.mute_bit};
      ADDR_GAIN_L: d.rd_data = q.host_gain_l;
      ADDR_GAIN_R: d.rd_data = q.host_gain_r;
      ADDR_ATT_L: d.rd_data = q.att_reg_l;
      ADDR_ATT_R: d.rd_data = q.att_reg_r;
      ADDR_ALC_CTRL: d.rd_data = q.alc_ctrl;
      ADDR_ALC_TIME: d.rd_data = q.alc_time;
      ADDR_ALC_REF: d.rd_data = q.alc_ref;
      ADDR_STATUS: d.rd_data = {q.alc, mute_req, pend_l | pend_r, 3'h0};
      default: d.rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q <= '{ch_sel: CH_SEL_RST, mute_bit: 1'b0, host_gain_l: GAIN_RST, host_gain_r: GAIN_RST,
             att_reg_l: ATT_RST, att_reg_r: ATT_RST, alc_ctrl: ALC_CTRL_RST, alc_time: ALC_TIME_RST,
             alc_ref: ALC_REF_RST, mute_s1: 1'b0, mute_s2: 1'b0, sign_l: 1'b0, sign_r: 1'b0,
             att_cur_l: ATT_RST, att_cur_r: ATT_RST, ramp_cnt: 4'h0, alc: ALC_OFF, alc_cnt: '0,
             alc_gain: GAIN_RST, rd_data: 8'h00};
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // input gain stages
  agl_gain_chan #(.GW(8), .CW(14)) u_chan_l (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .fs_tick(smp.valid),
    .zero_cross(zc_l),
    .load(load_l),
    .load_val(load_val_l),
    .force_en(force_en),
    .force_val(force_val),
    .tmo(zc_tmo),
    .gain_q(gain_l_q),
    .pending_q(pend_l)
  );

  agl_gain_chan #(.GW(8), .CW(14)) u_chan_r (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .fs_tick(smp.valid),
    .zero_cross(zc_r),
    .load(load_r),
    .load_val(load_val_r),
    .force_en(force_en),
    .force_val(force_val),
    .tmo(zc_tmo),
    .gain_q(gain_r_q),
    .pending_q(pend_r)
  );

  assign reg_rd_data_q = q.rd_data;
  assign ch_sel_q = q.ch_sel;
  assign att_l_q = q.att_cur_l;
  assign att_r_q = q.att_cur_r;

  // ==========================================================
  // checks
  a_gain_ignore: assert property (@(posedge clk_sys) disable iff (!nrst) // R8
    reg_wr.wr && reg_wr.addr == ADDR_GAIN_L && alc_on && reg_wr.data > GAIN_ALC_AREA |=> $stable(q.host_gain_l))
    else $error("gain write above 7FH taken under level control");

  a_att_write: assert property (@(posedge clk_sys) disable iff (!nrst) // R10
    reg_wr.wr && reg_wr.addr == ADDR_ATT_L |=> q.att_reg_l == $past(reg_wr.data))
    else $error("attenuation write lost");

  a_ramp_smooth: assert property (@(posedge clk_sys) disable iff (!nrst) // R11
    1'b1 |=> (att_l_q == $past(att_l_q)) || (att_l_q == $past(att_l_q) + 8'h01) || (att_l_q == $past(att_l_q) - 8'h01))
    else $error("attenuator jumped more than one step");

  a_mute_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // R23
    mute_req && att_l_q == ATT_MUTE && q.mute_bit && $stable(q.mute_bit) |=> att_l_q == ATT_MUTE)
    else $error("attenuator left mute while muted");

  a_alc_start: assert property (@(posedge clk_sys) disable iff (!nrst) // R21
    q.alc == ALC_OFF && alc_on |=> gain_r_q == $past(gain_l_q) && gain_l_q == $past(gain_l_q))
    else $error("level control did not start from left gain");

  a_limit_entry: assert property (@(posedge clk_sys) disable iff (!nrst) // R19
    q.alc == ALC_RECOVER && alc_on && smp.valid && over_lim |=> q.alc == ALC_LIMIT)
    else $error("overload in recovery did not return to limiter");

  a_recov_reset: assert property (@(posedge clk_sys) disable iff (!nrst) // R20
    q.alc == ALC_RECOVER && alc_on && smp.valid && !over_lim && over_rec |=> q.alc_cnt == '0)
    else $error("recovery wait timer not reset");

  a_limit_down: assert property (@(posedge clk_sys) disable iff (!nrst) // R14
    q.alc == ALC_LIMIT && alc_on && force_en |=> gain_l_q == gain_r_q && gain_l_q <= $past(q.alc_gain))
    else $error("limiter step not common or not downward");

  a_recov_cap: assert property (@(posedge clk_sys) disable iff (!nrst) // R18
    q.alc == ALC_RECOVER && alc_on && q.alc_gain <= q.alc_ref && $stable(q.alc_ref) |=> q.alc_gain <= q.alc_ref)
    else $error("recovery overshot the reference");

  a_alc_exit: assert property (@(posedge clk_sys) disable iff (!nrst) // R9
    q.alc != ALC_OFF && !alc_on |=> q.alc == ALC_OFF && (pend_l || gain_l_q == q.host_gain_l))
    else $error("host gain not restored after level control");

  c_limit: cover property (@(posedge clk_sys) disable iff (!nrst) q.alc == ALC_RECOVER ##1 q.alc == ALC_LIMIT);
  c_recov_step: cover property (@(posedge clk_sys) disable iff (!nrst)
    q.alc == ALC_RECOVER && force_en);
  c_mute_full: cover property (@(posedge clk_sys) disable iff (!nrst) mute_req && att_l_q == ATT_MUTE);

endmodule // agl_top

// [test/agl_host_model.sv]
/*
  host model: writes and reads the control registers of the level control block.
  assumes the block takes a write and a read address on the rising clk_sys edge.
*/
`timescale 1ns/10ps
module agl_host_model import agl_pkg::*; (
  input wire logic clk_sys,
  input wire logic [7:0] rd_data,
  output agl_wr_s reg_wr,
  output logic [4:0] rd_addr
);
  // ==========================================================
  // bus tasks, driven on the falling edge
  initial begin
    reg_wr = '0;
    rd_addr = 5'h00;
  end
  // attenuation writes above 90H are clamped to 90H
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] v;
    begin
      v = d;
      if ((a == ADDR_ATT_L || a == ADDR_ATT_R) && v > 8'h90) v = 8'h90;
      @(negedge clk_sys);
      reg_wr <= '{wr: 1'b1, addr: a, data: v};
      @(negedge clk_sys);
      reg_wr <= '0;
    end
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    begin
      @(negedge clk_sys);
      rd_addr <= a;
      @(negedge clk_sys);
      d = rd_data;
    end
  endtask
endmodule // agl_host_model

// [test/agl_top_tb_top.sv]
/*
  self-checking bench of the level control block: gains, attenuators, mute.
  assumes the host model drives the register port and the bench the samples.
*/
`timescale 1ns/10ps
module agl_top_tb_top import agl_pkg::*;;
  logic clk_sys, nrst, mute_pin, sl, sr;
  logic [23:0] amp;
  // about 200 ms of fs at 48 kHz
  localparam int CH_HOLD_FS = 9600;
  agl_wr_s reg_wr;
  agl_smp_s smp;
  logic [4:0] rd_addr;
  logic [7:0] rd_data, gl, gr, al, ar, d, g, r1, r2, a_l;
  logic [2:0] ch_sel, c;
  int errors, check_count;
  agl_top agl_top_i (.clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr), .reg_rd_addr(rd_addr),
    .reg_rd_data_q(rd_data), .mute_pin(mute_pin), .smp(smp), .ch_sel_q(ch_sel), .gain_l_q(gl),
    .gain_r_q(gr), .att_l_q(al), .att_r_q(ar));
  agl_host_model agl_host_model_i (.clk_sys(clk_sys), .rd_data(rd_data), .reg_wr(reg_wr), .rd_addr(rd_addr));
  // ==========================================================
  // helpers
  function automatic logic [7:0] clamp(input logic [7:0] v);
    return (v > GAIN_MAX) ? GAIN_MAX : v;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      check_count++;
      if (got !== exp) begin
        errors++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic pulses(input int n, input logic fl, input logic fr);
    begin
      repeat (n) begin
        @(negedge clk_sys);
        sl ^= fl;
        sr ^= fr;
        smp <= '{valid: 1'b1, left: sl ? (24'h000000 - amp) : amp, right: sr ? (24'h000000 - amp) : amp};
      end
      @(negedge clk_sys);
      smp.valid <= 1'b0;
    end
  endtask
  task automatic finish_test();
    begin
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ==========================================================
  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #500000;
    errors++;
    finish_test();
  end
  // ==========================================================
  // tests
  initial begin
    nrst = 1'b0;
    mute_pin = 1'b0;
    amp = 24'h000100;
    smp = '0;
    sl = 1'b0;
    sr = 1'b0;
    errors = 0;
    check_count = 0;
    void'($urandom(6));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst <= 1'b1;
    agl_host_model_i.rd(ADDR_ATT_L, d);
    chk(d, ATT_RST);
    chk(gl, GAIN_RST);
    chk(al, ATT_RST);
    agl_host_model_i.rd(5'h1F, d);
    chk(d, 8'h00);
    $display("reset test done");
    g = 8'h80 + 8'($urandom % 40);
    agl_host_model_i.wr(ADDR_GAIN_L, g);
    pulses(4, 1'b0, 1'b0);
    chk(gl, GAIN_RST);
    pulses(1, 1'b1, 1'b0);
    chk(gl, clamp(g));
    chk(gr, GAIN_RST);
    $display("zero cross test done");
    r1 = 8'h80 + 8'($urandom % 37);
    r2 = 8'h80 + 8'($urandom % 37);
    agl_host_model_i.wr(ADDR_GAIN_R, r1);
    pulses(int'(ZC_TMO2) - 8, 1'b0, 1'b0);
    chk(gr, GAIN_RST);
    agl_host_model_i.wr(ADDR_GAIN_R, r2);
    pulses(int'(ZC_TMO2) - 8, 1'b0, 1'b0);
    chk(gr, GAIN_RST);
    pulses(16, 1'b0, 1'b0);
    chk(gr, r2);
    $display("timeout test done");
    agl_host_model_i.wr(ADDR_ALC_REF, 8'hA8);
    agl_host_model_i.wr(ADDR_ALC_CTRL, 8'h01);
    pulses(2, 1'b0, 1'b0);
    chk(gr, clamp(g));
    agl_host_model_i.wr(ADDR_GAIN_L, 8'h40);
    agl_host_model_i.wr(ADDR_GAIN_L, 8'hC0);
    a_l = 8'($urandom % 144);
    agl_host_model_i.wr(ADDR_ATT_L, a_l);
    agl_host_model_i.rd(ADDR_ATT_L, d);
    chk(d, a_l);
    amp = 24'h600000;
    pulses(1, 1'b0, 1'b0);
    agl_host_model_i.rd(ADDR_STATUS, d);
    chk({5'h00, d[7:5]}, {5'h00, 3'(ALC_LIMIT)});
    pulses(3, 1'b1, 1'b0);
    chk(gr, clamp(g) - 8'h03);
    amp = 24'h100000;
    pulses(201, 1'b0, 1'b0);
    amp = 24'h300000;
    pulses(2, 1'b0, 1'b0);
    amp = 24'h100000;
    pulses(200, 1'b0, 1'b0);
    chk(gl, clamp(g) - 8'h03);
    pulses(int'(WAIT_TMO0) - 200, 1'b0, 1'b0);
    chk(gl, clamp(g) - 8'h02);
    agl_host_model_i.wr(ADDR_ALC_CTRL, 8'h00);
    pulses(1, 1'b1, 1'b1);
    chk(gl, 8'h40);
    chk(gr, r2);
    agl_host_model_i.wr(ADDR_ALC_CTRL, 8'h07);
    amp = 24'h7C0000;
    pulses(int'(LIM_TMO0) + 1, 1'b1, 1'b1);
    chk(gl, 8'h3F);
    chk(gr, 8'h3F);
    agl_host_model_i.wr(ADDR_ALC_CTRL, 8'h00);
    pulses(1, 1'b1, 1'b1);
    chk(gr, r2);
    $display("level control test done");
    agl_host_model_i.wr(ADDR_ATT_R, 8'h8F);
    pulses(MUTE_FS, 1'b0, 1'b0);
    chk(al, a_l);
    chk(ar, 8'h8F);
    agl_host_model_i.wr(ADDR_MUTE, 8'h01);
    pulses(MUTE_FS, 1'b0, 1'b0);
    chk(ar, ATT_MUTE);
    chk(al, ATT_MUTE);
    c = 3'($urandom % 5);
    agl_host_model_i.wr(ADDR_CH_SEL, {5'h00, c});
    chk({5'h00, ch_sel}, {5'h00, c});
    pulses(CH_HOLD_FS, 1'b0, 1'b0);
    chk(ar, ATT_MUTE);
    agl_host_model_i.wr(ADDR_MUTE, 8'h00);
    mute_pin <= 1'b1;
    pulses(MUTE_FS, 1'b0, 1'b0);
    chk(ar, ATT_MUTE);
    mute_pin <= 1'b0;
    pulses(24, 1'b0, 1'b0);
    chk({7'h00, ar <= 8'h05}, 8'h01);
    pulses(MUTE_FS, 1'b0, 1'b0);
    chk(ar, 8'h8F);
    chk(al, a_l);
    $display("mute test done");
    finish_test();
  end
endmodule // agl_top_tb_top
